//--- sim/pisc_issue_ctrl_assertions.sv
// concurrent checks for the issue and stall control block
module pisc_issue_ctrl_assertions #(parameter DATA_W = 32) (
    input wire core_clk, rst, instr_valid, cache_miss, io_busy, io_bus_stall, cop_busy,
    input wire [31:0] instr_word,
    input wire [DATA_W-1:0] base_reg_data, wb_data, result_latch, dcache_addr_latch,
    input wire [DATA_W-1:0] next_pc_slot, faulting_pc_slot, program_status_word, fetch_pc,
    input wire issue, wb_en, trap_redirect, halted
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire [3:0] op = instr_word[31:28];
    wire [DATA_W-1:0] disp_x = {{(DATA_W-16){instr_word[15]}}, instr_word[15:0]};
    wire quiet = instr_valid && op == 4'h0 && !halted && !trap_redirect
        && !(cache_miss || io_busy || io_bus_stall || cop_busy);
    logic [4:0] quiet_q;
    // saturating, so the miss countdown and synchronisers have drained by 20
    always @(posedge core_clk or posedge rst) begin
        if (rst) quiet_q <= 5'h00;
        else if (!quiet) quiet_q <= 5'h00;
        else if (quiet_q != 5'h1F) quiet_q <= quiet_q + 5'h01;
    end
    property p_la_addr;
        issue && $past(op) == 4'hD |->
            dcache_addr_latch == ($past(base_reg_data) >> 2) + $past(disp_x);
    endproperty
    a_la_addr: assert property (p_la_addr) else $error("load address wrong");
    property p_wb_pipe; wb_en |-> wb_data == $past(result_latch); endproperty
    a_wb_pipe: assert property (p_wb_pipe) else $error("writeback not from result");
    property p_res_pipe; $changed(result_latch) |-> result_latch == $past(dcache_addr_latch);
    endproperty
    a_res_pipe: assert property (p_res_pipe) else $error("result not from cache addr");
    property p_illegal;
        $rose(program_status_word[0]) |-> next_pc_slot == faulting_pc_slot + 1'b1;
    endproperty
    a_illegal: assert property (p_illegal) else $error("trap pc slots wrong");
    property p_halt; halted |=> halted && !issue; endproperty
    a_halt: assert property (p_halt) else $error("halt not held");
    property p_rate; quiet_q >= 5'h14 |-> issue; endproperty
    a_rate: assert property (p_rate) else $error("no issue without stall");
    property p_io; (io_busy && op == 4'hA) [*4] |-> !issue; endproperty
    a_io: assert property (p_io) else $error("io issued while busy");
    property p_io_bus; (io_bus_stall && op == 4'hA) [*4] |-> !issue; endproperty
    a_io_bus: assert property (p_io_bus) else $error("io issued in bus stall");
    property p_cop; (cop_busy && op == 4'hB) [*4] |-> !issue; endproperty
    a_cop: assert property (p_cop) else $error("coproc issued while busy");
    property p_miss; $rose(cache_miss) |-> ##4 !issue [*8]; endproperty
    a_miss: assert property (p_miss) else $error("issue during miss");
    property p_trap;
        $rose(program_status_word[0]) |-> ##[0:6] (trap_redirect && fetch_pc == 0);
    endproperty
    a_trap: assert property (p_trap) else $error("no trap redirect");
    c_wb: cover property (wb_en);
    c_halt: cover property ($rose(halted));
    c_trap: cover property (trap_redirect);
endmodule // pisc_issue_ctrl_assertions

bind pisc_issue_ctrl pisc_issue_ctrl_assertions #(.DATA_W(DATA_W)) chk_inst (.core_clk, .rst,
    .instr_valid, .cache_miss, .io_busy, .io_bus_stall, .cop_busy, .instr_word, .base_reg_data,
    .wb_data, .result_latch, .dcache_addr_latch, .next_pc_slot, .faulting_pc_slot,
    .program_status_word, .fetch_pc, .issue, .wb_en, .trap_redirect, .halted);

//--- sim/pisc_issue_ctrl_tb.sv
// self-checking bench for the issue and stall control block
module pisc_issue_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst, instr_valid, kernel_mode, uses_addr_reg;
    logic cache_miss, io_busy, io_bus_stall, cop_busy;
    logic [31:0] instr_word, instr_pc, dest_reg_data, base_reg_data;
    wire issue, wb_en, trap_redirect, halted;
    wire [5:0] wb_reg;
    wire [31:0] wb_data, dcache_addr_latch, result_latch, operand_a_latch, operand_b_latch;
    wire [31:0] next_pc_slot, faulting_pc_slot, program_status_word, fetch_pc;
    int miscompares, n_checks;
    pisc_issue_ctrl #(.DATA_W(32)) pisc_issue_ctrl_inst (.core_clk, .rst, .instr_valid,
        .instr_word, .instr_pc, .kernel_mode, .uses_addr_reg, .dest_reg_data, .base_reg_data,
        .cache_miss, .io_busy, .io_bus_stall, .cop_busy, .issue, .wb_en, .wb_reg, .wb_data,
        .dcache_addr_latch, .result_latch, .operand_a_latch, .operand_b_latch, .next_pc_slot,
        .faulting_pc_slot, .program_status_word, .fetch_pc, .trap_redirect, .halted);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic do_reset;
        rst = 1'b1;
        instr_valid = 1'b0;
        {cache_miss, io_busy, io_bus_stall, cop_busy} = 4'h0;
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
    endtask
    // feeds w0 then w1, advancing on each issue; cyc counts edges used
    task automatic run(input logic [31:0] w0, w1, input int n, output int cyc);
        int k;
        k = 0;
        cyc = 0;
        instr_word = w0;
        instr_valid = 1'b1;
        while (k < n && cyc < 60) begin
            @(posedge core_clk);
            #1;
            cyc++;
            if (issue === 1'b1) begin
                k++;
                instr_word = w1;
            end
        end
        instr_valid = 1'b0;
        if (k < n) begin
            miscompares++;
            $display("mismatch at %0t: no issue before limit", $time);
            wrap_up();
        end
    endtask
    // sel 0 writeback, 1 trap redirect, 2 halted
    task automatic wait_on(input int sel);
        for (int i = 0; i < 20; i++) begin
            if ((sel == 0 && wb_en === 1'b1) || (sel == 1 && trap_redirect === 1'b1)
                || (sel == 2 && halted === 1'b1)) return;
            @(posedge core_clk);
            #1;
        end
        miscompares++;
        $display("mismatch at %0t: event not seen before limit", $time);
        wrap_up();
    endtask
    task automatic t_rate;
        int n;
        n = 0;
        do_reset();
        instr_word = 32'h00410000;
        instr_valid = 1'b1;
        repeat (25) begin
            @(posedge core_clk);
            #1;
            if (issue === 1'b1) n++;
        end
        instr_valid = 1'b0;
        chk(n >= 24, "issue rate");
        $display("t_rate done");
    endtask
    task automatic t_la;
        int c;
        do_reset();
        base_reg_data = 32'h00000100;
        run(32'hD1C1FFFF, 32'h00000000, 1, c);
        chk(dcache_addr_latch === 32'h0000003F, "effective address");
        wait_on(0);
        chk(wb_data === 32'h0000003F && wb_reg === 6'h07 && result_latch === 32'h0000003F,
            "writeback");
        $display("t_la done");
    endtask
    // spacing of pair a minus pair b must be d edges
    task automatic t_pair(input logic [31:0] a0, a1, b0, b1, input int d);
        int ca, cb;
        do_reset();
        run(a0, a1, 2, ca);
        do_reset();
        run(b0, b1, 2, cb);
        chk(ca - cb == d, "issue spacing");
        $display("t_pair done");
    endtask
    // sel picks miss, io busy, io bus stall or coproc busy, held for len edges
    task automatic t_stall(input int sel, input logic [3:0] op, input int len, lo, hi);
        int cb, cs;
        do_reset();
        run({op, 28'h0}, {op, 28'h0}, 2, cb);
        do_reset();
        {cache_miss, io_busy, io_bus_stall, cop_busy} = 4'h8 >> sel;
        fork
            begin
                repeat (len) @(posedge core_clk);
                #1;
                {cache_miss, io_busy, io_bus_stall, cop_busy} = 4'h0;
            end
            begin
                // let the stall pass the two-stage synchroniser before the first request
                repeat (2) @(posedge core_clk);
                #1;
                run({op, 28'h0}, {op, 28'h0}, 2, cs);
            end
        join
        chk(cs - cb >= lo && cs - cb <= hi, "stall length");
        $display("t_stall done");
    endtask
    task automatic t_user;
        int c;
        do_reset();
        instr_pc = 32'h00000040;
        run(32'hE0000000, 32'h00000000, 1, c);
        wait_on(1);
        chk(program_status_word[0] === 1'b1 && faulting_pc_slot === 32'h00000040
            && next_pc_slot === 32'h00000041 && fetch_pc === 32'h00000000, "user trap");
        $display("t_user done");
    endtask
    task automatic t_kernel;
        int c;
        do_reset();
        kernel_mode = 1'b1;
        instr_pc = 32'h00000050;
        dest_reg_data = 32'h00000011;
        base_reg_data = 32'h00000022;
        run(32'hF0C40000, 32'h00000000, 1, c);
        wait_on(2);
        chk(operand_a_latch === 32'h00000011 && operand_b_latch === 32'h00000022
            && fetch_pc === 32'h00000051, "kernel halt");
        $display("t_kernel done");
    endtask
    initial begin
        miscompares = 0;
        n_checks = 0;
        kernel_mode = 1'b0;
        uses_addr_reg = 1'b0;
        instr_word = 32'h00000000;
        instr_pc = 32'h00000000;
        dest_reg_data = 32'h00000000;
        base_reg_data = 32'h00000000;
        t_rate();
        t_la();
        t_pair(32'hD1400000, 32'hD0050000, 32'hD1400000, 32'hD0060000, 1);
        t_pair(32'hD0000000, 32'hD0000000, 32'hD0000000, 32'hD0060000, 0);
        uses_addr_reg = 1'b1;
        t_pair(32'hD1800000, 32'h00060000, 32'hD1800000, 32'h00050000, 1);
        uses_addr_reg = 1'b0;
        t_pair(32'h30000000, 32'h20000000, 32'h00000000, 32'h20000000, 1);
        t_stall(0, 4'h0, 1, 12, 16);
        t_stall(1, 4'hA, 10, 7, 14);
        t_stall(2, 4'hA, 10, 7, 14);
        t_stall(3, 4'hB, 10, 7, 14);
        t_user();
        t_kernel();
        wrap_up();
    end
endmodule // pisc_issue_ctrl_tb

//--- src/pisc_defs.vh
// constants for the pipeline issue and stall control block
`ifndef PISC_DEFS_VH
`define PISC_DEFS_VH
`define PISC_OP_LOAD_ADDR 4'hD
`define PISC_OP_UNDEF1 4'hE
`define PISC_OP_UNDEF2 4'hF
`define PISC_OP_LOAD 4'h2
`define PISC_OP_STORE 4'h3
`define PISC_OP_TRAP 4'hC
`define PISC_OP_IO 4'hA
`define PISC_OP_COPROC 4'hB
`define PISC_OPC_MSB 31
`define PISC_OPC_LSB 28
`define PISC_DST_MSB 27
`define PISC_DST_LSB 22
`define PISC_BASE_MSB 21
`define PISC_BASE_LSB 16
`define PISC_DISP_MSB 15
`define PISC_DISP_LSB 0
`define PISC_WORD_SHIFT 2
`define PISC_MISS_CYCLES 8'd13
`define PISC_TRAP_CYCLES 8'd3
`define PISC_COP_MAX_CYCLES 8'd58
`define PISC_PSW_ILLEGAL_BIT 0
`define PISC_PSW_RESET 32'h00000000
`define PISC_TRAP_VECTOR 32'h00000000
`endif

//--- src/pisc_issue_ctrl.v
// issue and stall control: load address, undefined opcode, timing stalls
`include "pisc_defs.vh"

// Overview of operation
// RULE1: load address result is base register shifted right two plus displacement.
// RULE2: result forms in decode into cache address latch, then result latch, then register.
// RULE3: load address whose base was just modified stalls issue one cycle.
// RULE4: user-mode undefined opcode sets illegal bit, faulting pc and next pc.
// RULE5: kernel-mode undefined opcode halts; pc next, operand latches hold fields.
// RULE6: one instruction issued per cycle unless a stall is active.
// RULE7: io instruction while io outstanding stalls, extended by bus and select stalls; here only io_bus_stall extends it, there is no select stall input.
// RULE8: coprocessor instruction waits for preceding coprocessor operation, up to 58.
// RULE9: cache miss on fetch, load or store stalls about 13 cycles.
// RULE10: any trap delays three cycles before executing address zero.
// RULE11: load or store right after a store loses one issue cycle.
// RULE12: address use of register written by previous instruction stalls; register zero exempt.
module pisc_issue_ctrl #(
    parameter DATA_W = 32
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // instruction in decode
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire [DATA_W-1:0] instr_pc,
    input wire kernel_mode,
    input wire uses_addr_reg,
    // register file read data
    input wire [DATA_W-1:0] dest_reg_data,
    input wire [DATA_W-1:0] base_reg_data,
    // stall sources from elsewhere
    input wire cache_miss,
    input wire io_busy,
    input wire io_bus_stall,
    input wire cop_busy,
    // issue and writeback
    output reg issue,
    output reg wb_en,
    output reg [5:0] wb_reg,
    output reg [DATA_W-1:0] wb_data,
    output reg [DATA_W-1:0] dcache_addr_latch,
    output reg [DATA_W-1:0] result_latch,
    output reg [DATA_W-1:0] operand_a_latch,
    output reg [DATA_W-1:0] operand_b_latch,
    // trap state
    output reg [DATA_W-1:0] next_pc_slot,
    output reg [DATA_W-1:0] faulting_pc_slot,
    output reg [DATA_W-1:0] program_status_word,
    output reg [DATA_W-1:0] fetch_pc,
    output reg trap_redirect,
    output reg halted
);
    localparam ST_RUN = 2'd0;
    localparam ST_TRAP = 2'd1;
    localparam ST_HALT = 2'd2;

    // pin-level stall sources, two-stage synchronised
    reg miss_s1_q, miss_q, iob_s1_q, iob_q, iobs_s1_q, iobs_q, cop_s1_q, cop_q;
    reg [1:0] state_q;
    reg [3:0] prev_opc_q;
    reg [5:0] prev_dst_q;
    reg prev_wr_q, prev_valid_q, interlock_done_q;
    reg ex_la_q, wr_la_q;
    reg [5:0] ex_dst_q, wr_dst_q;
    wire trap_busy;
    wire miss_busy;

    wire [3:0] opc = instr_word[`PISC_OPC_MSB:`PISC_OPC_LSB];
    wire [5:0] dst_f = instr_word[`PISC_DST_MSB:`PISC_DST_LSB];
    wire [5:0] base_f = instr_word[`PISC_BASE_MSB:`PISC_BASE_LSB];
    wire [15:0] disp_f = instr_word[`PISC_DISP_MSB:`PISC_DISP_LSB];

    function is_mem;
        input [3:0] op;
        begin
            is_mem = (op == `PISC_OP_LOAD) || (op == `PISC_OP_STORE);
        end
    endfunction

    function writes_reg;
        input [3:0] op;
        begin
            writes_reg = (op == `PISC_OP_LOAD) || (op == `PISC_OP_LOAD_ADDR);
        end
    endfunction

    wire is_la = (opc == `PISC_OP_LOAD_ADDR);
    wire is_undef = (opc == `PISC_OP_UNDEF1) || (opc == `PISC_OP_UNDEF2);
    wire addr_use = is_la || is_mem(opc) || uses_addr_reg;
    // register zero is the pc, so writing it never interlocks
    wire interlock = instr_valid && addr_use && prev_valid_q && prev_wr_q &&
        (prev_dst_q == base_f) && (base_f != 6'd0) && !interlock_done_q; // RULE3 RULE12
    wire store_pen = instr_valid && prev_valid_q && (prev_opc_q == `PISC_OP_STORE) &&
        is_mem(opc) && !interlock_done_q; // RULE11
    wire io_stall = instr_valid && (opc == `PISC_OP_IO) && (iob_q || iobs_q); // RULE7
    wire cop_stall = instr_valid && (opc == `PISC_OP_COPROC) && cop_q; // RULE8
    wire one_cycle = interlock || store_pen;
    wire stall = (state_q != ST_RUN) || trap_busy || miss_busy || miss_q ||
        one_cycle || io_stall || cop_stall;
    wire go = instr_valid && !stall; // RULE6
    wire undef_go = go && is_undef;
    wire trap_go = go && (opc == `PISC_OP_TRAP) && !kernel_mode;
    wire [DATA_W-1:0] next_seq = instr_pc + {{(DATA_W-1){1'b0}}, 1'b1};
    wire [DATA_W-1:0] ea = (base_reg_data >> `PISC_WORD_SHIFT) +
        {{(DATA_W-16){disp_f[15]}}, disp_f}; // RULE1

    // miss stall lasts a fixed count once the miss is seen
    pisc_stall_cnt #(.WIDTH(8)) u_miss (
        .core_clk(core_clk),
        .rst(rst),
        .load(miss_q && !miss_busy),
        .count(`PISC_MISS_CYCLES - 8'd1),
        .busy(miss_busy)
    ); // RULE9

    pisc_stall_cnt #(.WIDTH(8)) u_trap (
        .core_clk(core_clk),
        .rst(rst),
        .load((undef_go && !kernel_mode) || trap_go),
        .count(`PISC_TRAP_CYCLES),
        .busy(trap_busy)
    ); // RULE10

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            miss_s1_q <= 1'b0;
            miss_q <= 1'b0;
            iob_s1_q <= 1'b0;
            iob_q <= 1'b0;
            iobs_s1_q <= 1'b0;
            iobs_q <= 1'b0;
            cop_s1_q <= 1'b0;
            cop_q <= 1'b0;
        end else begin
            miss_s1_q <= cache_miss;
            miss_q <= miss_s1_q;
            iob_s1_q <= io_busy;
            iob_q <= iob_s1_q;
            iobs_s1_q <= io_bus_stall;
            iobs_q <= iobs_s1_q;
            cop_s1_q <= cop_busy;
            cop_q <= cop_s1_q;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RUN;
            issue <= 1'b0;
            wb_en <= 1'b0;
            wb_reg <= 6'd0;
            wb_data <= {DATA_W{1'b0}};
            dcache_addr_latch <= {DATA_W{1'b0}};
            result_latch <= {DATA_W{1'b0}};
            operand_a_latch <= {DATA_W{1'b0}};
            operand_b_latch <= {DATA_W{1'b0}};
            next_pc_slot <= {DATA_W{1'b0}};
            faulting_pc_slot <= {DATA_W{1'b0}};
            program_status_word <= `PISC_PSW_RESET;
            fetch_pc <= {DATA_W{1'b0}};
            trap_redirect <= 1'b0;
            halted <= 1'b0;
            prev_opc_q <= 4'h0;
            prev_dst_q <= 6'd0;
            prev_wr_q <= 1'b0;
            prev_valid_q <= 1'b0;
            interlock_done_q <= 1'b0;
            ex_la_q <= 1'b0;
            wr_la_q <= 1'b0;
            ex_dst_q <= 6'd0;
            wr_dst_q <= 6'd0;
        end else begin
            issue <= go;
            trap_redirect <= 1'b0;
            interlock_done_q <= one_cycle ? 1'b1 : (go ? 1'b0 : interlock_done_q);
            if (go) begin
                prev_opc_q <= opc;
                prev_dst_q <= dst_f;
                prev_wr_q <= writes_reg(opc);
                prev_valid_q <= 1'b1;
                fetch_pc <= next_seq;
            end else if (!one_cycle && !instr_valid) begin
                prev_valid_q <= 1'b0;
            end
            // three-stage load address path
            ex_la_q <= go && is_la;
            ex_dst_q <= dst_f;
            wr_la_q <= ex_la_q;
            wr_dst_q <= ex_dst_q;
            if (go && is_la) begin
                dcache_addr_latch <= ea; // RULE1 RULE2
            end
            if (ex_la_q) begin
                result_latch <= dcache_addr_latch; // RULE2
            end
            wb_en <= wr_la_q;
            wb_reg <= wr_dst_q;
            wb_data <= result_latch; // RULE2
            if (undef_go) begin
                operand_a_latch <= dest_reg_data;
                operand_b_latch <= base_reg_data;
            end
            case (state_q)
                ST_RUN: begin
                    if (undef_go && kernel_mode) begin
                        state_q <= ST_HALT; // RULE5
                        halted <= 1'b1;
                        fetch_pc <= next_seq;
                    end else if ((undef_go && !kernel_mode) || trap_go) begin
                        state_q <= ST_TRAP;
                        faulting_pc_slot <= instr_pc; // RULE4
                        next_pc_slot <= next_seq;
                        if (undef_go) begin
                            program_status_word[`PISC_PSW_ILLEGAL_BIT] <= 1'b1; // RULE4
                        end
                    end
                end
                ST_TRAP: begin
                    // wait out the trap delay, then fetch the vector
                    if (!trap_busy) begin
                        state_q <= ST_RUN;
                        fetch_pc <= `PISC_TRAP_VECTOR; // RULE10
                        trap_redirect <= 1'b1;
                        prev_valid_q <= 1'b0;
                    end
                end
                ST_HALT: begin
                    // halt holds until reset
                    state_q <= ST_HALT;
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end
endmodule // pisc_issue_ctrl

//--- src/pisc_stall_cnt.v
// countdown timer for fixed-length stalls
module pisc_stall_cnt #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // control
    input wire load,
    input wire [WIDTH-1:0] count,
    output wire busy
);
    reg [WIDTH-1:0] cnt_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != {WIDTH{1'b0}}) begin
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    assign busy = (cnt_q != {WIDTH{1'b0}});
endmodule // pisc_stall_cnt
